// ### design/audio_port_irq_pkg.sv
// Operation
// - No receive interrupt unless receive enable set
// - Overrun rising with error enable sets error pending
// - Writing 1 to receive clear clears pending
// - Writing 1 to receive-error clear clears pending
// - Writing 1 to transmit clear clears pending
// - Writing 1 to transmit-error clear clears pending
// - Writing 0 to clear bits changes nothing
// - Pending flags read-only, set only by hardware
// - Low byte: pending bits 7-4, enables 3-0
// - Bits 11-8 clear bits, bits 15-12 reserved
// - One interrupt request, chosen by enable bits
// - Almost-empty with transmit enable sets transmit pending
// - Underrun with error enable sets error pending
package audio_port_irq_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned NUM_SRC = 4;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_CLEAR  = 8'h0C;

  // ==========================================================
  // Field positions in the status and control word
  localparam int unsigned EN_LSB   = 0;
  localparam int unsigned PEND_LSB = 4;
  localparam int unsigned CLR_LSB  = 8;
  localparam int unsigned RSV_LSB  = 12;

  // Source indices inside every four-bit field
  localparam int unsigned SRC_RX     = 0;
  localparam int unsigned SRC_RX_ERR = 1;
  localparam int unsigned SRC_TX     = 2;
  localparam int unsigned SRC_TX_ERR = 3;

  // ==========================================================
  // Reset values and trigger styles
  localparam logic [3:0] ENABLE_RST = 4'h0;
  localparam logic [3:0] EDGE_MASK  = 4'h2;

  // ==========================================================
  // Event sources from the audio datapath, same clock
  typedef struct packed {
    logic tx_underrun_flag;
    logic tx_almost_empty_flag;
    logic rx_overrun_flag;
    logic rx_warning_flag;
  } irq_src_t;

endpackage

// ### design/pending_flag.sv
`timescale 1ns/1ps
`default_nettype none
module pending_flag #(
  parameter bit EDGE = 1'b0
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic cond,
  input  wire logic enable,
  input  wire logic clear,
  output logic      pending
);

  logic cond_q;
  logic hit;
  logic set;
  logic next_pending;

  // ==========================================================
  // Trigger: rising edge or level of the source
  assign hit          = EDGE ? (cond & ~cond_q) : cond;
  assign set          = enable & hit;
  // Set wins over a clear in the same cycle
  assign next_pending = set | (pending & ~clear);

  // Flag and edge history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cond_q  <= 1'b0;
      pending <= 1'b0;
    end else begin
      cond_q  <= cond;
      pending <= next_pending;
    end
  end

endmodule // pending_flag
`default_nettype wire

// ### design/audio_port_interrupt_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module audio_port_interrupt_ctrl (
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     audio_module_clock_on,
  input  wire audio_port_irq_pkg::irq_src_t source_flags,
  output logic                          audio_irq
);

  // ==========================================================
  // Address decode
  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  logic        hit_ctrl;
  logic        hit_status;
  logic        hit_enable;
  logic        hit_clear;
  logic        hit_any;
  logic        setup_phase;
  logic        access_phase;
  logic        write_ok;
  logic        refuse;

  assign hit_ctrl     = addr_is(paddr, audio_port_irq_pkg::OFS_CTRL);
  assign hit_status   = addr_is(paddr, audio_port_irq_pkg::OFS_STATUS);
  assign hit_enable   = addr_is(paddr, audio_port_irq_pkg::OFS_ENABLE);
  assign hit_clear    = addr_is(paddr, audio_port_irq_pkg::OFS_CLEAR);
  assign hit_any      = hit_ctrl | hit_status | hit_enable | hit_clear;
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  // Access with the module clock off is refused
  assign refuse       = ~hit_any | ~audio_module_clock_on;
  assign write_ok     = access_phase & pwrite & ~pslverr;
  assign pready       = 1'b1;

  // ==========================================================
  // Enable bits and clear pulses
  logic [3:0] int_enable;
  logic [3:0] next_enable;
  logic [3:0] pending;
  logic [3:0] clear_pulse;
  logic       en_from_ctrl;
  logic       en_from_reg;
  logic [3:0] clr_from_ctrl;
  logic [3:0] clr_from_reg;

  assign en_from_ctrl  = write_ok & hit_ctrl & pstrb[0];
  assign en_from_reg   = write_ok & hit_enable & pstrb[0];
  // Only ones in the clear field act; zeros are ignored
  assign clr_from_ctrl = (write_ok & hit_ctrl & pstrb[1]) ?
    pwdata[audio_port_irq_pkg::CLR_LSB +: 4] : 4'h0;
  assign clr_from_reg  = (write_ok & hit_clear & pstrb[0]) ?
    pwdata[3:0] : 4'h0;
  assign clear_pulse   = clr_from_ctrl | clr_from_reg;

  // Pending bits 7..4 of a write are dropped
  assign next_enable =
    en_from_ctrl ? pwdata[audio_port_irq_pkg::EN_LSB +: 4] :
    en_from_reg  ? pwdata[3:0] : int_enable;

  // Enable register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_enable <= audio_port_irq_pkg::ENABLE_RST;
    end else begin
      int_enable <= next_enable;
    end
  end

  // ==========================================================
  // One sticky pending flag per source
  logic [3:0] src_vec;

  assign src_vec = source_flags;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_flag
      // Receive overrun counts on its rising edge
      pending_flag #(
        .EDGE (audio_port_irq_pkg::EDGE_MASK[i])
      ) u_flag (
        .clk     (clk),
        .arst_n  (arst_n),
        .cond    (src_vec[i]),
        .enable  (int_enable[i]),
        .clear   (clear_pulse[i]),
        .pending (pending[i])
      );
    end
  endgenerate

  // Single request line to the interrupt controller
  assign audio_irq = |pending;

  // ==========================================================
  // Read data and error, captured in the setup cycle
  logic [15:0] ctrl_word;
  logic [31:0] read_mux;

  // Reserved and clear bits read as zero
  assign ctrl_word = {4'h0, 4'h0, pending, int_enable};
  assign read_mux  =
    (refuse | pwrite) ? 32'h0000_0000 :
    hit_ctrl   ? {16'h0000, ctrl_word} :
    hit_status ? {28'h000_0000, pending} :
    hit_enable ? {28'h000_0000, int_enable} : 32'h0000_0000;

  // Bus answer registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= read_mux;
      pslverr <= refuse;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic ctrl_setup_rd;
  assign ctrl_setup_rd = setup_phase & ~pwrite & hit_ctrl &
                         audio_module_clock_on;

  chk_rx_held_off: assert property (
    !int_enable[0] && !pending[0] |=> !pending[0])
    else $error("receive pending set while disabled");

  chk_rx_sets_pend: assert property (
    int_enable[0] && source_flags.rx_warning_flag |=> pending[0])
    else $error("receive pending not set");

  chk_rxerr_rise: assert property (
    int_enable[1] && $rose(source_flags.rx_overrun_flag)
    |=> pending[1])
    else $error("overrun did not set error pending");

  chk_rxerr_held_off: assert property (
    !int_enable[1] && !pending[1] |=> !pending[1])
    else $error("error pending set while disabled");

  chk_rx_clear: assert property (
    clear_pulse[0] && !(int_enable[0] &&
      source_flags.rx_warning_flag) |=> !pending[0])
    else $error("receive clear failed");

  chk_rxerr_clear: assert property (
    clear_pulse[1] && !(int_enable[1] &&
      $rose(source_flags.rx_overrun_flag)) |=> !pending[1])
    else $error("receive error clear failed");

  chk_tx_clear: assert property (
    clear_pulse[2] && !(int_enable[2] &&
      source_flags.tx_almost_empty_flag) |=> !pending[2])
    else $error("transmit clear failed");

  chk_txerr_clear: assert property (
    write_ok && hit_ctrl && pstrb[1] && pwdata[11] &&
    !(int_enable[3] && source_flags.tx_underrun_flag)
    |=> !pending[3])
    else $error("transmit error clear failed");

  chk_zero_keeps: assert property (
    write_ok && hit_ctrl && pwdata[11:8] == 4'h0
    |=> (pending & $past(pending)) == $past(pending))
    else $error("zero clear write dropped a flag");

  chk_write_no_pend: assert property (
    write_ok && hit_status && pending == 4'h0 &&
    !(|(int_enable & src_vec))
    |=> pending == 4'h0)
    else $error("status write changed pending");

  chk_enable_write: assert property (
    en_from_ctrl |=> int_enable == $past(pwdata[3:0]))
    else $error("enable field not written");

  chk_read_layout: assert property (
    ctrl_setup_rd |=> prdata[31:8] == 24'h00_0000 &&
      prdata[7:0] == {$past(pending), $past(int_enable)})
    else $error("status word layout wrong");

  chk_irq_cause: assert property (
    $rose(audio_irq) |-> $past(|(int_enable & src_vec)))
    else $error("request rose without enabled cause");

  chk_tx_sets_pend: assert property (
    int_enable[2] && source_flags.tx_almost_empty_flag
    |=> pending[2] && audio_irq)
    else $error("transmit pending not set");

  chk_txerr_sets: assert property (
    int_enable[3] && source_flags.tx_underrun_flag
    |=> pending[3] [*1] ##0 audio_irq)
    else $error("transmit error pending not set");

  chk_clk_off_refuse: assert property (
    setup_phase && !audio_module_clock_on
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("access with clock off not refused");

  chk_irq_or: assert property (
    pending == 4'h0 ##1 pending == 4'h0 |-> !audio_irq)
    else $error("request high with nothing pending");

  // ==========================================================
  // Bus side checks: aliases, lanes, refusals, held answers
  logic rd_setup;

  // Read setup cycle that the block will answer
  assign rd_setup = setup_phase & ~pwrite & audio_module_clock_on;

  chk_enable_alias: assert property (
    en_from_reg
    |=> int_enable == $past(pwdata[3:0]))
    else $error("enable alias not written");

  chk_enable_hold: assert property (
    !en_from_ctrl && !en_from_reg
    |=> $stable(int_enable))
    else $error("enable changed without a write");

  chk_status_read: assert property (
    rd_setup && hit_status
    |=> prdata == {28'h000_0000, $past(pending)})
    else $error("status read wrong");

  chk_enable_read: assert property (
    rd_setup && hit_enable
    |=> prdata == {28'h000_0000, $past(int_enable)})
    else $error("enable read wrong");

  chk_clear_read: assert property (
    rd_setup && hit_clear
    |=> prdata == 32'h0000_0000)
    else $error("clear register read not zero");

  chk_unmapped_err: assert property (
    setup_phase && !hit_any
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  chk_refused_write: assert property (
    access_phase && pwrite && pslverr
    |=> $stable(int_enable))
    else $error("refused write changed enables");

  chk_answer_held: assert property (
    !setup_phase
    |=> $stable(prdata) && $stable(pslverr))
    else $error("bus answer moved outside setup");

  chk_alias_rx_clr: assert property (
    clr_from_reg[0] && !(int_enable[0] &&
      source_flags.rx_warning_flag) |=> !pending[0])
    else $error("receive alias clear failed");

  chk_alias_rxe_clr: assert property (
    clr_from_reg[1] && !(int_enable[1] &&
      $rose(source_flags.rx_overrun_flag)) |=> !pending[1])
    else $error("receive error alias clear failed");

  chk_alias_tx_clr: assert property (
    clr_from_reg[2] && !(int_enable[2] &&
      source_flags.tx_almost_empty_flag) |=> !pending[2])
    else $error("transmit alias clear failed");

  chk_alias_txe_clr: assert property (
    clr_from_reg[3] && !(int_enable[3] &&
      source_flags.tx_underrun_flag) |=> !pending[3])
    else $error("transmit error alias clear failed");

  chk_tx_held_off: assert property (
    !int_enable[2] && !pending[2]
    |=> !pending[2])
    else $error("transmit pending set while disabled");

  chk_txerr_held_off: assert property (
    !int_enable[3] && !pending[3]
    |=> !pending[3])
    else $error("transmit error pending set while disabled");

  chk_pend_sticky: assert property (
    pending != 4'h0
    |=> (pending & $past(pending & ~clear_pulse)) ==
        $past(pending & ~clear_pulse))
    else $error("pending flag dropped without clear");

  chk_lane_enable: assert property (
    write_ok && hit_ctrl && !pstrb[0]
    |=> $stable(int_enable))
    else $error("enable written without its lane");

  chk_lane_clear: assert property (
    write_ok && hit_ctrl && !pstrb[1]
    |=> (pending & $past(pending)) == $past(pending))
    else $error("clear acted without its lane");

  chk_pend_no_write: assert property (
    write_ok && hit_ctrl && pwdata[11:8] == 4'h0 &&
    !(|(int_enable & src_vec))
    |=> pending == $past(pending))
    else $error("control write changed pending");

  chk_irq_quiet: assert property (
    pending == 4'h0 && !(|(int_enable & src_vec))
    |=> !audio_irq)
    else $error("request rose without a cause");

  chk_clear_needs_wr: assert property (
    !write_ok |-> clear_pulse == 4'h0)
    else $error("clear pulse without a write");

  cov_alias_clear: cover property (clr_from_reg != 4'h0);

  cov_rx_set_clear: cover property (
    !pending[0] ##1 pending[0] ##[1:20] !pending[0]);

  cov_irq_rise: cover property ($rose(audio_irq));

  cov_refused: cover property (access_phase && pslverr);

  cov_set_beats_clear: cover property (
    clear_pulse[3] && int_enable[3] &&
    source_flags.tx_underrun_flag);

endmodule // audio_port_interrupt_ctrl
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // Stimulus and observed signals
  logic                          clk = 1'b1;
  logic                          arst_n = 1'b0;
  logic                          psel = 1'b0;
  logic                          penable = 1'b0;
  logic                          pwrite = 1'b0;
  logic [7:0]                    paddr = 8'h00;
  logic [31:0]                   pwdata = 32'h0;
  logic [3:0]                    pstrb = 4'h0;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic                          audio_module_clock_on = 1'b1;
  audio_port_irq_pkg::irq_src_t  source_flags = '0;
  logic                          audio_irq;
  int                            mismatches = 0;
  int                            checks_done = 0;
  int                            cycles = 0;
  logic [31:0]                   rd;
  logic                          err;
  logic [3:0]                    strb = 4'hF;

  audio_port_interrupt_ctrl audio_port_interrupt_ctrl_inst (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .audio_module_clock_on(audio_module_clock_on),
    .source_flags(source_flags), .audio_irq(audio_irq));

  // ==========================================================
  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= strb;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Hold one source high for two cycles, then drop it
  task automatic pulse(input int i);
    @(posedge clk);
    source_flags <= audio_port_irq_pkg::irq_src_t'(4'h1 << i);
    repeat (2) @(posedge clk);
    source_flags <= '0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    chk("irq reset", 32'h0, 32'(audio_irq));
  endtask

  // Unmapped place, clock off, write to read-only status
  task automatic t_refuse();
    apb(1'b1, 8'h10, 32'hF);
    chk("unmapped err", 32'h1, 32'(err));
    audio_module_clock_on <= 1'b0;
    apb(1'b1, 8'h00, 32'hF);
    chk("clock off err", 32'h1, 32'(err));
    audio_module_clock_on <= 1'b1;
    apb(1'b1, 8'h04, 32'hF);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl untouched", 32'h0, rd);
  endtask

  // Source i: disabled, enabled, zero-clear, one-clear
  task automatic t_source(input int i);
    logic [31:0] en;
    en = 32'h1 << i;
    pulse(i);
    apb(1'b0, 8'h00, 32'h0);
    chk("disabled pend", 32'h0, rd);
    chk("disabled irq", 32'h0, 32'(audio_irq));
    apb(1'b1, 8'h00, en);
    pulse(i);
    apb(1'b0, 8'h00, 32'h0);
    chk("pend set", en | (en << 4), rd);
    chk("irq set", 32'h1, 32'(audio_irq));
    apb(1'b1, 8'h00, 32'hF0 | en);
    apb(1'b0, 8'h00, 32'h0);
    chk("zero clear", en | (en << 4), rd);
    apb(1'b1, 8'h00, en | (en << 8));
    apb(1'b0, 8'h00, 32'h0);
    chk("one clear", en, rd);
    chk("irq clear", 32'h0, 32'(audio_irq));
    apb(1'b1, 8'h00, 32'h0);
  endtask

  // Alias registers and byte lanes
  task automatic t_alias();
    apb(1'b1, 8'h08, 32'h5);
    apb(1'b0, 8'h08, 32'h0);
    chk("enable alias", 32'h5, rd);
    chk("ready", 32'h1, 32'(pready));
    pulse(0);
    apb(1'b0, 8'h04, 32'h0);
    chk("status read", 32'h1, rd);
    strb = 4'h1;
    apb(1'b1, 8'h00, 32'h105);
    apb(1'b0, 8'h00, 32'h0);
    chk("clear lane off", 32'h15, rd);
    strb = 4'h2;
    apb(1'b1, 8'h00, 32'h1F0);
    strb = 4'hF;
    apb(1'b0, 8'h00, 32'h0);
    chk("enable lane off", 32'h5, rd);
    pulse(0);
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk("clear reads zero", 32'h0, rd);
    apb(1'b0, 8'h04, 32'h0);
    chk("alias clear", 32'h0, rd);
    apb(1'b1, 8'h08, 32'h0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_refuse();
    for (int i = 0; i < 4; i++) begin
      t_source(i);
    end
    t_alias();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
